// file: rtl/frame_mac_pkg.sv
/*
 Constants, register map and types of the serial bus frame MAC.
 Assumes a 32-bit APB slave port and a physical layer that hands over one bit per strobe.
*/
package frame_mac_pkg;
	// frame geometry in bits, data limit in bytes, table sizes
	localparam logic [6:0] HDR_BITS = 7'h10;
	localparam logic [6:0] FCS_BITS = 7'h0f;
	localparam logic [6:0] MIN_FRAME_BITS = 7'h1f;
	localparam logic [6:0] MAX_FRAME_BITS = 7'h5f;
	localparam logic [6:0] RW_LAST_CNT = 7'h0e;
	localparam logic [6:0] RTR_POS = 7'h0f;
	localparam logic [3:0] MAX_BYTES = 4'h8;
	localparam int N_PROD = 4;
	localparam int N_CONS = 4;
	// check sequence generator
	localparam logic [14:0] CRC_POLY = 15'h0f9d;
	localparam logic [14:0] CRC_INIT = 15'h7fff;
	localparam logic [14:0] CRC_RESIDUE = 15'h4b15;
	// command bits inside the 16-bit header (bit 0 is the last one on the bus)
	localparam int HDR_EXT = 3;
	localparam int HDR_RAK = 2;
	localparam int HDR_RW = 1;
	localparam int HDR_RTR = 0;
	localparam logic EXT_VAL = 1'b1;
	localparam logic RW_READ = 1'b1;
	localparam logic RW_WRITE = 1'b0;
	localparam logic RTR_REQ = 1'b1;
	localparam logic RTR_DATA = 1'b0;
	// register byte offsets
	localparam logic [11:0] OFF_CTRL = 12'h000;
	localparam logic [11:0] OFF_TX_ID = 12'h004;
	localparam logic [11:0] OFF_STATUS = 12'h008;
	localparam logic [11:0] OFF_RX_INFO = 12'h00c;
	localparam logic [11:0] OFF_ERR = 12'h010;
	localparam logic [11:0] OFF_TX_DATA = 12'h020;
	localparam logic [11:0] OFF_RX_DATA = 12'h040;
	localparam logic [11:0] OFF_PROD_ID = 12'h060;
	localparam logic [11:0] OFF_CONS_ID = 12'h080;
	localparam logic [11:0] OFF_PROD_DATA = 12'h0a0;
	// field positions
	localparam int CTRL_GO = 0;
	localparam int CTRL_RAK = 1;
	localparam int CTRL_REQ = 2;
	localparam int CTRL_AUTO = 3;
	localparam int CTRL_LEN = 8;
	localparam int TBL_EN = 15;
	localparam int TBL_LEN = 16;
	localparam logic [31:0] RESET_WORD = 32'h0000_0000;
	typedef enum logic [1:0] {
		TX_IDLE = 2'b00,
		TX_WAIT = 2'b01,
		TX_SEND = 2'b10,
		TX_LISTEN = 2'b11
	} tx_state_type;
endpackage

// file: rtl/serial_bus_frame_mac.sv
/*
 Frame MAC: builds, arbitrates, receives and checks frames, answers remote requests
 from the producer table and filters received frames through the consumer table.
 Assumes a physical layer that codes the line, inserts SOF/EOD/ACK/EOF, handles
 interframe spacing and gives one bit strobe per bit slot, and an APB master.
*/
// Local design decisions: the register addresses and the APB register port.
// Overview of operation
// - request frame: no data, R/W coded read, RTR coded remote request
// - bit before RTR in a request is driven to its read value
// - initiator of a request sends only identifier and command, then yields; here it yields only on losing RTR, else sends the check sequence too
// - serialize and deserialize byte by byte, first byte first, MSB first
// - frame invalid unless whole format SOF through EOF is correct
// - identifier through check sequence length must lie within min and max
// - any code violation in identifier, command, data or check marks invalid
// - data field not a whole number of bytes marks frame invalid
// - CRC over received bits must match received check value
// - frame requesting acknowledgement needs a positive acknowledge
// - frame without acknowledgement request needs acknowledge-absent value
// - any invalid frame may be reported to network administration
// - no LLC invalid report for short or unselected frames
// - remote request matching producer table is answered with stored data; here only when its RAK bit is clear and the transmitter is idle
// - producer entry holds identifier and data; data updated by LLC
// - frames reach the LLC only when the consumer table matches; here rx_data is overwritten by every frame, only status, rx info and error cause are gated
// - consumer table is read-only to the MAC logic
// - slave transmits only when polled; autonomous module may always send
// - contention resolved by non-destructive bitwise arbitration
// - each access attempt yields exactly one complete frame on the bus
// - 15-bit generator preset to ones, sends inverted remainder highest first
// - receive register must hold the fixed residue after all bits
// - RTR of one means no data, a request to send
// - RAK of one asks receivers for positive in-frame acknowledgement
`timescale 1ns/1ps
module serial_bus_frame_mac import frame_mac_pkg::*; (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// physical layer bit interface
	input wire logic phy_bus_free,
	input wire logic phy_rx_sof,
	input wire logic phy_bit_strobe,
	input wire logic phy_rx_bit,
	input wire logic phy_rx_viol,
	input wire logic phy_rx_eod,
	input wire logic phy_rx_eof,
	input wire logic phy_rx_ack_pos,
	input wire logic phy_rx_fmt_ok,
	output logic phy_tx_req,
	output logic phy_tx_on,
	output logic phy_tx_bit,
	output logic phy_tx_eod,
	output logic phy_ack_req,
	// network administration
	output logic netadm_invalid
);
	function automatic logic [14:0] crc_step(input logic [14:0] c, input logic b);
		crc_step = {c[13:0], 1'b0} ^ (((c[14] ^ b) == 1'b1) ? CRC_POLY : 15'h0000);
	endfunction
	function automatic logic [3:0] clamp_len(input logic [3:0] len);
		clamp_len = (len > MAX_BYTES) ? MAX_BYTES : len;
	endfunction

	tx_state_type tx_state;
	logic [15:0] tx_hdr;
	logic [3:0] tx_len;
	logic [6:0] tx_pos;
	logic [14:0] tx_crc;
	logic tx_resp;
	logic [1:0] tx_entry;
	logic rx_active;
	logic rx_eod_seen;
	logic rx_viol;
	logic [6:0] rx_cnt;
	logic [14:0] rx_crc;
	logic [15:0] rx_hdr;
	logic [6:0] rx_shift;
	logic ctrl_rak;
	logic ctrl_req;
	logic ctrl_auto;
	logic [3:0] ctrl_len;
	logic [11:0] tx_id;
	logic [4:0] events;
	logic [11:0] rx_id;
	logic [3:0] rx_com;
	logic [3:0] rx_nbytes;
	logic [5:0] err_cause;
	logic [N_PROD-1:0] prod_en;
	logic [N_CONS-1:0] cons_en;
	logic [7:0] tx_data [0:7];
	logic [7:0] rx_data [0:7];
	logic [7:0] prod_data [0:N_PROD*8-1];
	logic [11:0] prod_id [0:N_PROD-1];
	logic [3:0] prod_len [0:N_PROD-1];
	logic [11:0] cons_id [0:N_CONS-1];

	// apb decode: one wait state, write takes effect at the edge with pready high
	wire wr_en = psel & penable & pready & pwrite;
	wire rd_phase = psel & penable & ~pready;
	wire aligned = paddr[1:0] == 2'b00;
	wire sel_ctrl = paddr == OFF_CTRL;
	wire sel_txid = paddr == OFF_TX_ID;
	wire sel_status = paddr == OFF_STATUS;
	wire sel_rxinfo = paddr == OFF_RX_INFO;
	wire sel_err = paddr == OFF_ERR;
	wire sel_txd = aligned && paddr[11:3] == OFF_TX_DATA[11:3];
	wire sel_rxd = aligned && paddr[11:3] == OFF_RX_DATA[11:3];
	wire sel_pid = aligned && paddr[11:4] == OFF_PROD_ID[11:4];
	wire sel_cid = aligned && paddr[11:4] == OFF_CONS_ID[11:4];
	wire sel_pdat = aligned && paddr[11:5] == OFF_PROD_DATA[11:5];
	wire mapped = sel_ctrl | sel_txid | sel_status | sel_rxinfo | sel_err | sel_txd | sel_rxd
		| sel_pid | sel_cid | sel_pdat;
	wire [2:0] wsel = {paddr[2], 2'b00};
	wire [4:0] psel_byte = {paddr[4:3], paddr[2], 2'b00};
	wire [1:0] tidx = paddr[3:2];
	wire [31:0] rd_value =
		sel_ctrl ? {20'h0_0000, ctrl_len, 4'h0, ctrl_auto, ctrl_req, ctrl_rak, 1'b0} :
		sel_txid ? {20'h0_0000, tx_id} :
		sel_status ? {26'h000_0000, events, tx_state != TX_IDLE} :
		sel_rxinfo ? {12'h000, rx_nbytes, rx_com, rx_id} :
		sel_err ? {26'h000_0000, err_cause} :
		sel_txd ? {tx_data[wsel], tx_data[wsel + 3'h1], tx_data[wsel + 3'h2],
			tx_data[wsel + 3'h3]} :
		sel_rxd ? {rx_data[wsel], rx_data[wsel + 3'h1], rx_data[wsel + 3'h2],
			rx_data[wsel + 3'h3]} :
		sel_pid ? {12'h000, prod_len[tidx], prod_en[tidx], 3'h0, prod_id[tidx]} :
		sel_cid ? {16'h0000, cons_en[tidx], 3'h0, cons_id[tidx]} :
		sel_pdat ? {prod_data[psel_byte], prod_data[psel_byte + 5'h01],
			prod_data[psel_byte + 5'h02], prod_data[psel_byte + 5'h03]} :
		RESET_WORD;

	// table lookups, producer in the R/W bit slot after the RAK bit, consumer on the identifier bits rx_hdr[15:4]
	logic prod_hit;
	logic [1:0] prod_idx;
	logic cons_hit;
	wire [11:0] poll_id = rx_hdr[13:2];
	always_comb begin
		prod_hit = 1'b0;
		prod_idx = 2'b00;
		cons_hit = 1'b0;
		for (int i = 0; i < N_PROD; i++) begin
			if (prod_en[i] && prod_id[i] == poll_id && !prod_hit) begin
				prod_hit = 1'b1;
				prod_idx = 2'(i);
			end
		end
		for (int i = 0; i < N_CONS; i++) begin
			if (cons_en[i] && cons_id[i] == rx_hdr[15:4]) begin
				cons_hit = 1'b1;
			end
		end
	end

	// transmit bit sequencing
	wire [6:0] data_end = HDR_BITS + {tx_len, 3'b000};
	wire [6:0] ntx_pos = tx_pos + 7'h01;
	wire [6:0] ntx_off = ntx_pos - HDR_BITS;
	wire [2:0] ntx_byte = ntx_off[5:3];
	wire [3:0] hdr_idx = 4'hf - ntx_pos[3:0];
	wire [2:0] bit_idx = 3'h7 - ntx_off[2:0];
	wire [7:0] ntx_data = tx_resp ? prod_data[{tx_entry, ntx_byte}] : tx_data[ntx_byte];
	wire [14:0] ntx_crc = (tx_pos < data_end) ? crc_step(tx_crc, phy_tx_bit)
		: {tx_crc[13:0], 1'b0};
	wire ntx_bit = (ntx_pos < HDR_BITS) ? tx_hdr[hdr_idx] :
		(ntx_pos < data_end) ? ntx_data[bit_idx] : ~ntx_crc[14];
	wire tx_last = tx_pos == data_end + FCS_BITS - 7'h01;
	wire tx_slot = phy_bit_strobe && tx_state == TX_SEND;
	wire tx_mismatch = tx_slot && phy_rx_bit != phy_tx_bit;
	wire tx_yield = tx_mismatch && !tx_resp && tx_pos == RTR_POS
		&& tx_hdr[HDR_RTR] == RTR_REQ;

	// receive checks
	wire rx_take = phy_bit_strobe && rx_active && !rx_eod_seen;
	wire [6:0] rx_off = rx_cnt - HDR_BITS;
	wire [6:0] rx_dbits = rx_cnt - MIN_FRAME_BITS;
	wire rx_byte_done = rx_cnt >= HDR_BITS && rx_off[2:0] == 3'h7 && rx_off[6:3] < 7'(MAX_BYTES);
	wire [14:0] nrx_crc = crc_step(rx_crc, phy_rx_bit);
	wire hdr_full = rx_cnt >= HDR_BITS;
	wire len_ok = rx_cnt >= MIN_FRAME_BITS && rx_cnt <= MAX_FRAME_BITS;
	wire align_ok = rx_dbits[2:0] == 3'h0;
	wire crc_ok = rx_crc == CRC_RESIDUE;
	wire body_ok = len_ok && align_ok && crc_ok && !rx_viol;
	wire rak = rx_hdr[HDR_RAK];
	wire ack_ok = rak ? phy_rx_ack_pos : !phy_rx_ack_pos;
	wire frame_end = phy_rx_eof && rx_active;
	wire frame_valid = phy_rx_fmt_ok && rx_eod_seen && body_ok && ack_ok;
	wire own_frame = tx_state == TX_LISTEN || tx_state == TX_SEND;
	wire rx_sel = hdr_full && cons_hit && !own_frame;
	wire poll_hit = rx_take && rx_cnt == RW_LAST_CNT && phy_rx_bit == RW_READ && prod_hit
		&& tx_state == TX_IDLE && rx_hdr[0] == 1'b0;
	wire go = wr_en && sel_ctrl && pwdata[CTRL_GO] && pwdata[CTRL_AUTO]
		&& tx_state == TX_IDLE;

	wire own_end = frame_end && own_frame;
	wire [4:0] ev_set = {own_end && tx_resp, // response sent
		frame_end && !frame_valid && rx_sel,
		frame_end && frame_valid && rx_sel && rx_hdr[HDR_RTR] == RTR_DATA,
		own_end && !tx_resp && frame_valid, own_end && !tx_resp && !frame_valid};
	wire [4:0] ev_clr = (wr_en && sel_status) ? pwdata[5:1] : 5'h00;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= RESET_WORD;
		end else begin
			pready <= rd_phase;
			pslverr <= rd_phase && !mapped;
			prdata <= rd_phase ? rd_value : RESET_WORD;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_rak <= 1'b0;
			ctrl_req <= 1'b0;
			ctrl_auto <= 1'b0;
			ctrl_len <= 4'h0;
			tx_id <= 12'h000;
			prod_en <= '0;
			cons_en <= '0;
			events <= 5'h00;
		end else begin
			if (wr_en && sel_ctrl) begin
				ctrl_rak <= pwdata[CTRL_RAK];
				ctrl_req <= pwdata[CTRL_REQ];
				ctrl_auto <= pwdata[CTRL_AUTO];
				ctrl_len <= pwdata[CTRL_LEN +: 4];
			end
			if (wr_en && sel_txid) begin
				tx_id <= pwdata[11:0];
			end
			if (wr_en && sel_pid) begin
				prod_en[tidx] <= pwdata[TBL_EN];
			end
			if (wr_en && sel_cid) begin
				cons_en[tidx] <= pwdata[TBL_EN];
			end
			// a hardware set in the same cycle as a clear wins
			events <= (events & ~ev_clr) | ev_set;
		end
	end

	// table and buffer storage: data only, validity lives in the enable bits
	always_ff @(posedge pclk) begin
		for (int i = 0; i < 4; i++) begin
			if (wr_en && sel_txd) begin
				tx_data[{paddr[2], 2'(i)}] <= pwdata[8*(3-i) +: 8];
			end
			if (wr_en && sel_pdat) begin
				prod_data[{paddr[4:3], paddr[2], 2'(i)}] <= pwdata[8*(3-i) +: 8];
			end
		end
		if (wr_en && sel_pid) begin
			prod_id[tidx] <= pwdata[11:0];
			prod_len[tidx] <= clamp_len(pwdata[TBL_LEN +: 4]);
		end
		if (wr_en && sel_cid) begin
			cons_id[tidx] <= pwdata[11:0];
		end
		if (rx_take && rx_byte_done) begin
			rx_data[rx_off[5:3]] <= {rx_shift, phy_rx_bit};
		end
	end

	// receiver: runs on every frame, including our own, until the end of frame
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_active <= 1'b0;
			rx_eod_seen <= 1'b0;
			rx_viol <= 1'b0;
			rx_cnt <= 7'h00;
			rx_crc <= CRC_INIT;
			rx_hdr <= 16'h0000;
			rx_shift <= 7'h00;
		end else if (phy_rx_sof) begin
			rx_active <= 1'b1;
			rx_eod_seen <= 1'b0;
			rx_viol <= 1'b0;
			rx_cnt <= 7'h00;
			rx_crc <= CRC_INIT;
		end else begin
			if (rx_take) begin
				rx_crc <= nrx_crc;
				rx_cnt <= (rx_cnt == 7'h7f) ? rx_cnt : rx_cnt + 7'h01;
				rx_shift <= {rx_shift[5:0], phy_rx_bit};
				rx_viol <= rx_viol | phy_rx_viol;
				if (!hdr_full) begin
					rx_hdr <= {rx_hdr[14:0], phy_rx_bit};
				end
			end
			if (phy_rx_eod && rx_active) begin
				rx_eod_seen <= 1'b1;
			end
			if (frame_end) begin
				rx_active <= 1'b0;
			end
		end
	end

	// delivered frame details and error causes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_id <= 12'h000;
			rx_com <= 4'h0;
			rx_nbytes <= 4'h0;
			err_cause <= 6'h00;
		end else if (frame_end && rx_sel) begin
			if (frame_valid) begin
				rx_id <= rx_hdr[15:4];
				rx_com <= rx_hdr[3:0];
				rx_nbytes <= rx_dbits[6:3];
			end else begin
				err_cause <= {!ack_ok, !crc_ok, !align_ok, rx_viol, !len_ok,
					!(phy_rx_fmt_ok && rx_eod_seen)};
			end
		end
	end

	// transmitter
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_state <= TX_IDLE;
			tx_hdr <= 16'h0000;
			tx_len <= 4'h0;
			tx_pos <= 7'h00;
			tx_crc <= CRC_INIT;
			tx_resp <= 1'b0;
			tx_entry <= 2'b00;
			phy_tx_bit <= 1'b1;
		end else begin
			case (tx_state)
				TX_IDLE: begin
					if (go) begin
						tx_state <= TX_WAIT;
						tx_resp <= 1'b0;
						if (pwdata[CTRL_REQ]) begin
							tx_hdr <= {tx_id, EXT_VAL, pwdata[CTRL_RAK], RW_READ, RTR_REQ};
							tx_len <= 4'h0;
						end else begin
							tx_hdr <= {tx_id, EXT_VAL, pwdata[CTRL_RAK], RW_WRITE, RTR_DATA};
							tx_len <= clamp_len(pwdata[CTRL_LEN +: 4]);
						end
					end else if (poll_hit) begin
						tx_state <= TX_SEND;
						tx_resp <= 1'b1;
						tx_entry <= prod_idx;
						tx_len <= prod_len[prod_idx];
						tx_hdr <= {poll_id, rx_hdr[1:0], phy_rx_bit, RTR_DATA};
						tx_pos <= RTR_POS;
						tx_crc <= nrx_crc;
						phy_tx_bit <= RTR_DATA;
					end
				end
				TX_WAIT: begin
					if (phy_rx_sof) begin
						tx_state <= TX_SEND;
						tx_pos <= 7'h00;
						tx_crc <= CRC_INIT;
						phy_tx_bit <= tx_hdr[15];
					end
				end
				TX_SEND: begin
					if (frame_end) begin
						tx_state <= TX_IDLE;
					end else if (tx_yield) begin
						tx_state <= TX_IDLE;
					end else if (tx_mismatch) begin
						// lost arbitration: keep receiving; a data or request frame retries once the bus is free, a response gives up
						tx_state <= tx_resp ? TX_IDLE : TX_WAIT;
						phy_tx_bit <= 1'b1;
					end else if (tx_slot) begin
						tx_crc <= ntx_crc;
						tx_pos <= ntx_pos;
						phy_tx_bit <= tx_last ? 1'b1 : ntx_bit;
						if (tx_last) begin
							tx_state <= TX_LISTEN;
						end
					end
				end
				TX_LISTEN: begin
					if (frame_end) begin
						tx_state <= TX_IDLE;
					end
				end
				default: begin
					tx_state <= TX_IDLE;
				end
			endcase
		end
	end

	// physical layer strobes and levels, all registered
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phy_tx_req <= 1'b0;
			phy_tx_on <= 1'b0;
			phy_tx_eod <= 1'b0;
			phy_ack_req <= 1'b0;
			netadm_invalid <= 1'b0;
		end else begin
			phy_tx_req <= tx_state == TX_WAIT && phy_bus_free && !phy_rx_sof;
			phy_tx_on <= tx_state == TX_SEND && !tx_mismatch && !(tx_slot && tx_last);
			phy_tx_eod <= tx_slot && !tx_mismatch && tx_last;
			phy_ack_req <= phy_rx_eod && rx_active && rak && hdr_full && cons_hit && !own_frame
				&& body_ok && rx_cnt <= MAX_FRAME_BITS;
			netadm_invalid <= frame_end && !frame_valid;
		end
	end
endmodule // serial_bus_frame_mac

// file: sim/frame_mac_asserts.sv
/*
 Port checker for the frame MAC: APB answer timing and bit-interface pulses.
 Assumes it is bound into serial_bus_frame_mac, one clock pclk, reset presetn.
*/
`timescale 1ns/1ps
module frame_mac_asserts (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// bit interface
	input wire logic phy_bus_free,
	input wire logic phy_rx_sof,
	input wire logic phy_bit_strobe,
	input wire logic phy_rx_bit,
	input wire logic phy_rx_viol,
	input wire logic phy_rx_eod,
	input wire logic phy_rx_eof,
	input wire logic phy_rx_ack_pos,
	input wire logic phy_rx_fmt_ok,
	input wire logic phy_tx_req,
	input wire logic phy_tx_on,
	input wire logic phy_tx_bit,
	input wire logic phy_tx_eod,
	input wire logic phy_ack_req,
	input wire logic netadm_invalid
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	sequence s_access;
		psel && penable && !pready;
	endsequence
	sequence s_answer;
		pready ##1 !pready;
	endsequence
	a_apb_one_wait: assert property (s_access |=> s_answer)
		else $error("apb answer not one cycle after access");
	a_err_with_ready: assert property (pslverr |-> pready)
		else $error("pslverr outside pready");
	a_rdata_quiet: assert property (!pready |-> prdata == 32'h0000_0000)
		else $error("prdata not zero between answers");
	a_req_when_free: assert property (phy_tx_req |-> $past(phy_bus_free))
		else $error("transmit request while bus busy");
	a_start_on_sof: assert property (phy_rx_sof && phy_tx_req |-> ##[1:2] phy_tx_on)
		else $error("access attempt did not start a frame");
	a_bit_stands: assert property (phy_tx_on && !$past(phy_bit_strobe) && !$past(phy_rx_sof)
		|-> $stable(phy_tx_bit))
		else $error("transmit bit changed between slots");
	a_eod_pulse: assert property (phy_tx_eod |=> !phy_tx_eod && !phy_tx_on)
		else $error("end of data not a single closing pulse");
	a_ack_after_eod: assert property (phy_ack_req |-> $past(phy_rx_eod))
		else $error("ack request not right after end of data");
	a_invalid_after_eof: assert property (netadm_invalid |-> $past(phy_rx_eof))
		else $error("invalid report not right after end of frame");
endmodule // frame_mac_asserts

bind serial_bus_frame_mac frame_mac_asserts i_chk (.pclk, .presetn, .psel, .penable, .pwrite,
	.paddr, .pwdata, .prdata, .pready, .pslverr, .phy_bus_free, .phy_rx_sof, .phy_bit_strobe,
	.phy_rx_bit, .phy_rx_viol, .phy_rx_eod, .phy_rx_eof, .phy_rx_ack_pos, .phy_rx_fmt_ok,
	.phy_tx_req, .phy_tx_on, .phy_tx_bit, .phy_tx_eod, .phy_ack_req, .netadm_invalid);

// file: sim/phy_bus_model.sv
/*
 Far side of the MAC: other bus modules plus the physical layer, as a bit stream.
 Assumes run() is called just after a rising edge; the bus is a wired AND, 0 dominant.
*/
`timescale 1ns/1ps
module phy_bus_model (
	// clock
	input wire logic pclk,
	// from the mac
	input wire logic phy_tx_req,
	input wire logic phy_tx_on,
	input wire logic phy_tx_bit,
	// to the mac
	output logic phy_bus_free,
	output logic phy_rx_sof,
	output logic phy_bit_strobe,
	output logic phy_rx_bit,
	output logic phy_rx_viol,
	output logic phy_rx_eod,
	output logic phy_rx_eof,
	output logic phy_rx_ack_pos,
	output logic phy_rx_fmt_ok
);
	logic [95:0] seen = '0;
	initial begin
		{phy_rx_sof, phy_bit_strobe, phy_rx_bit, phy_rx_viol} = 4'h0;
		{phy_rx_eod, phy_rx_eof, phy_rx_ack_pos, phy_rx_fmt_ok} = 4'h0;
		phy_bus_free = 1'b1;
	end
	task automatic run(input logic [95:0] fr, input int n, input int viol, input logic ack,
		input logic fmt, input logic wt);
		int k;
		logic b;
		// no local limit: a request that never comes ends in the bench timeout
		while (wt && phy_tx_req !== 1'b1) begin
			@(posedge pclk);
		end
		phy_bus_free <= 1'b0;
		phy_rx_sof <= 1'b1;
		@(posedge pclk);
		phy_rx_sof <= 1'b0;
		repeat (2) @(posedge pclk);
		for (k = n - 1; k >= 0; k--) begin
			b = fr[k] & (phy_tx_on ? phy_tx_bit : 1'b1);
			seen = {seen[94:0], b};
			phy_bit_strobe <= 1'b1;
			phy_rx_bit <= b;
			phy_rx_viol <= (k == viol);
			@(posedge pclk);
			phy_bit_strobe <= 1'b0;
			phy_rx_viol <= 1'b0;
			// between slots the line is not held at the last value
			phy_rx_bit <= ~b;
			repeat (2) @(posedge pclk);
		end
		phy_rx_eod <= 1'b1;
		@(posedge pclk);
		phy_rx_eod <= 1'b0;
		@(posedge pclk);
		phy_rx_eof <= 1'b1;
		phy_rx_ack_pos <= ack;
		phy_rx_fmt_ok <= fmt;
		@(posedge pclk);
		phy_rx_eof <= 1'b0;
		phy_rx_ack_pos <= ~ack;
		phy_rx_fmt_ok <= ~fmt;
		phy_bus_free <= 1'b1;
	endtask
endmodule // phy_bus_model

// file: sim/serial_bus_frame_mac_tb.sv
/*
 Self-checking bench: APB master, bit-level frame and check sequence model, bus partner.
 Assumes the MAC sits behind phy_bus_model and the checker is bound in.
*/
`timescale 1ns/1ps
module serial_bus_frame_mac_tb import frame_mac_pkg::*; ();
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd, rs = 42;
	logic pready, pslverr, phy_bus_free, phy_rx_sof, phy_bit_strobe, phy_rx_bit, er;
	logic phy_rx_viol, phy_rx_eod, phy_rx_eof, phy_rx_ack_pos, phy_rx_fmt_ok, phy_tx_req;
	logic phy_tx_on, phy_tx_bit, phy_tx_eod, phy_ack_req, netadm_invalid;
	logic [95:0] f, q;
	logic [11:0] id;
	logic [15:0] d;
	int fn, j, fail_count = 0, check_count = 0, cyc = 0, inv_cnt = 0, ack_cnt = 0, eod_cnt = 0;
	int eb [5] = '{4, 3, 2, 0, 5};
	serial_bus_frame_mac i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .phy_bus_free, .phy_rx_sof, .phy_bit_strobe, .phy_rx_bit,
		.phy_rx_viol, .phy_rx_eod, .phy_rx_eof, .phy_rx_ack_pos, .phy_rx_fmt_ok, .phy_tx_req,
		.phy_tx_on, .phy_tx_bit, .phy_tx_eod, .phy_ack_req, .netadm_invalid);
	phy_bus_model i_phy (.pclk, .phy_tx_req, .phy_tx_on, .phy_tx_bit, .phy_bus_free,
		.phy_rx_sof, .phy_bit_strobe, .phy_rx_bit, .phy_rx_viol, .phy_rx_eod, .phy_rx_eof,
		.phy_rx_ack_pos, .phy_rx_fmt_ok);
	always #25 pclk = ~pclk;
	always @(posedge pclk) begin
		cyc++;
		inv_cnt += (netadm_invalid === 1'b1);
		ack_cnt += (phy_ack_req === 1'b1);
		eod_cnt += (phy_tx_eod === 1'b1);
		// whole run needs under two thousand cycles
		if (cyc == 60000) begin
			fail_count++;
			wrap_up();
		end
	end
	function automatic logic [31:0] rnd();
		rs = {rs[30:0], rs[31] ^ rs[21] ^ rs[1] ^ rs[0]};
		return rs;
	endfunction
	task wrap_up();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task chk(input string nm, input logic [95:0] s, input logic [95:0] e);
		check_count++;
		if (s !== e) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1;
		@(posedge pclk);
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
	endtask
	task rdc(input string nm, input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
		apb(1'b0, a, 32'h0000_0000);
		chk(nm, rd & m, e);
	endtask
	task push(input logic [31:0] v, input int w);
		for (int i = w - 1; i >= 0; i--) begin
			f = {f[94:0], v[i]};
			fn++;
		end
	endtask
	task newf();
		f = '0;
		fn = 0;
	endtask
	task fcs();
		logic [14:0] r;
		r = CRC_INIT;
		for (int i = fn - 1; i >= 0; i--)
			r = (f[i] ^ r[14]) ? {r[13:0], 1'b0} ^ CRC_POLY : {r[13:0], 1'b0};
		push({17'h0_0000, ~r}, 15);
	endtask
	task txchk(input string nm);
		chk(nm, i_phy.seen & ~({96{1'b1}} << fn), f);
	endtask
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		rdc("ctrl reset", OFF_CTRL, 32'h0000_0000, 32'hffff_ffff);
		rdc("status reset", OFF_STATUS, 32'h0000_0000, 32'hffff_ffff);
		apb(1'b0, 12'hffc, 32'h0000_0000);
		chk("unmapped err", er, 1'h1);
		id = 12'(rnd());
		d = 16'(rnd());
		apb(1'b1, OFF_TX_ID, {20'h0_0000, id});
		apb(1'b1, OFF_TX_DATA, {d[7:0], 24'h00_0000});
		apb(1'b1, OFF_CTRL, 32'h0000_0109);
		newf();
		push(id, 12);
		push(4'h8, 4);
		push(d[7:0], 8);
		fcs();
		i_phy.run({96{1'b1}}, 39, -1, 1'b0, 1'b1, 1'b1);
		txchk("data frame");
		chk("end of data", eod_cnt, 1);
		rdc("tx done", OFF_STATUS, 32'h0000_0004, 32'h0000_0004);
		apb(1'b1, OFF_CTRL, 32'h0000_000d);
		newf();
		push(id, 12);
		push(4'hb, 4);
		fcs();
		i_phy.run({96{1'b1}}, 31, -1, 1'b0, 1'b1, 1'b1);
		txchk("request frame");
		apb(1'b1, OFF_STATUS, 32'h0000_003e);
		apb(1'b1, OFF_CTRL, 32'h0000_0001);
		repeat (10) @(posedge pclk);
		chk("slave request", phy_tx_req, 1'h0);
		apb(1'b1, OFF_CONS_ID, {20'h0_0008, id});
		rdc("cons entry", OFF_CONS_ID, {20'h0_0008, id}, 32'h0000_ffff);
		newf();
		push(id, 12);
		push(4'hc, 4);
		push(d, 16);
		fcs();
		i_phy.run(f, fn, -1, 1'b1, 1'b1, 1'b0);
		chk("ack request", ack_cnt, 1);
		rdc("rx ready", OFF_STATUS, 32'h0000_0008, 32'h0000_0008);
		rdc("rx data", OFF_RX_DATA, {d, 16'h0000}, 32'hffff_0000);
		rdc("rx info", OFF_RX_INFO, {16'h0002, 4'hc, id}, 32'h000f_ffff);
		// 0 crc, 1 align, 2 violation, 3 format, 4 ack, 5 unselected, 6 short header
		for (int k = 0; k < 7; k++) begin
			apb(1'b1, OFF_STATUS, 32'h0000_003e);
			j = inv_cnt;
			d = 16'(rnd());
			newf();
			push((k == 5) ? id ^ 12'h001 : id, 12);
			push(4'h8, 4);
			push(d, 16);
			fcs();
			if (k == 1)
				push(32'h0000_0001, 1);
			if (k == 0)
				f[0] = ~f[0];
			q = (k == 6) ? f >> (fn - 10) : f;
			i_phy.run(q, (k == 6) ? 10 : fn, (k == 2) ? 5 : -1, k == 4, k != 3, 1'b0);
			// the report pulse follows end of frame and is counted one edge later
			repeat (2) @(posedge pclk);
			chk("invalid report", inv_cnt - j, k != 5);
			rdc("rx status", OFF_STATUS, (k < 5) ? 32'h0000_0010 : 32'h0000_0000,
				32'h0000_0018);
			if (k < 5)
				rdc("err cause", OFF_ERR, 1 << eb[k], 1 << eb[k]);
		end
		id = 12'(rnd());
		d = 16'(rnd());
		apb(1'b1, OFF_PROD_ID, {20'h0_0018, id});
		apb(1'b1, OFF_PROD_DATA, {d[7:0], 24'h00_0000});
		rdc("prod data", OFF_PROD_DATA, {d[7:0], 24'h00_0000}, 32'hff00_0000);
		newf();
		push(id, 12);
		push(4'hb, 4);
		q = (f << 23) | 96'h7f_ffff;
		newf();
		push(id, 12);
		push(4'ha, 4);
		push(d[7:0], 8);
		fcs();
		i_phy.run(q, 39, -1, 1'b0, 1'b1, 1'b0);
		txchk("response frame");
		rdc("resp sent", OFF_STATUS, 32'h0000_0020, 32'h0000_0020);
		wrap_up();
	end
endmodule // serial_bus_frame_mac_tb
